//--- dv/adc_conversion_control_tb.sv
/*
  Self-checking testbench for the converter control block: register reset values,
  pin selection, reference select, power and a full conversion for each divider code 0 to 6.
  Assumes the design's own assertions guard the cycle-level relations inside the block.
*/
`timescale 1ns/1ps
module adc_conversion_control_tb
  import adc_ctrl_pkg::*;
;
  logic              clk = 1'b0;
  logic              reset = 1'b1;
  logic [ADDR_W-1:0] avs_address = '0;
  logic              avs_read = 1'b0;
  logic              avs_write = 1'b0;
  logic [3:0]        avs_byteenable = 4'hF;
  logic [31:0]       avs_writedata = '0;
  logic [31:0]       avs_readdata;
  logic              avs_waitrequest;
  logic [RES_W-1:0]  conv_result_data = '0;
  logic              conv_reset, conv_step, conv_power_on, bandgap_route, bandgap_enable;
  logic [2:0]        conv_channel;
  logic              reference_source_sel, vref_pin_shared_off, conv_irq;
  logic [PINS-1:0]   port_direction_control = '0;
  logic [PINS-1:0]   pullup_request = '0;
  logic [PINS-1:0]   analog_pin_enables, pin_digital_off, pin_input_dir, pin_pullup_on;
  int                err_count = 0;
  int                check_count = 0;
  logic [31:0]       expq[$];
  int                cyc = 0;
  int                step_cnt = 0;
  int                gap_err = 0;
  int                last_step = 0;
  int                per = 1;
  logic              step_clr = 1'b0;
  localparam int     SETTLE_CYC = 16;

  adc_conversion_control dut (
    .clk(clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .conv_result_data(conv_result_data), .conv_reset(conv_reset),
    .conv_step(conv_step), .conv_power_on(conv_power_on), .conv_channel(conv_channel),
    .bandgap_route(bandgap_route), .bandgap_enable(bandgap_enable),
    .reference_source_sel(reference_source_sel), .vref_pin_shared_off(vref_pin_shared_off),
    .port_direction_control(port_direction_control), .pullup_request(pullup_request),
    .analog_pin_enables(analog_pin_enables), .pin_digital_off(pin_digital_off),
    .pin_input_dir(pin_input_dir), .pin_pullup_on(pin_pullup_on), .conv_irq(conv_irq));

  always #4 clk = ~clk;

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  // The request is held until the edge that samples waitrequest low, then released.
  task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d, input logic [31:0] exp);
    @(posedge clk);
    avs_address   <= a;
    avs_write     <= wr;
    avs_read      <= ~wr;
    avs_writedata <= {24'h000000, d};
    if (!wr) expq.push_back(exp);
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    // One more edge lets a write land before the caller looks at the outputs.
    @(posedge clk);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Output watcher
  // ----------------------------------------------------------------------
  // Values are taken before the edge lands, so the watcher never races the design.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (avs_read && avs_waitrequest === 1'b0) begin
      if (expq.size() == 0) chk("read without note", 32'h1, 32'h0);
      else chk("readdata", expq.pop_front(), avs_readdata);
    end
    if (step_clr) begin
      step_cnt <= 0;
      gap_err  <= 0;
    end else if (conv_step === 1'b1) begin
      if (step_cnt > 0 && cyc - last_step != per) gap_err <= gap_err + 1;
      step_cnt  <= step_cnt + 1;
      last_step <= cyc;
    end
  end

  initial begin
    #(8 * 60000);
    err_count++;
    finish_test();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    logic [7:0]  e;
    logic [2:0]  ch;
    logic [11:0] d;
    logic        al;
    logic        en;
    void'($urandom(32'h630f94d4));
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    chk("power after reset", 32'h0, conv_power_on);
    bus(1'b0, OFF_CTRL0, 8'h00, 32'h00000060);
    bus(1'b0, OFF_CTRL1, 8'h00, 32'h00000000);
    bus(1'b0, OFF_PIN_EN, 8'h00, 32'h000000FF);
    bus(1'b0, 5'h14, 8'h00, 32'h00000000);
    $display("test reset values done");

    for (int i = 0; i < 4; i++) begin
      e = $urandom;
      port_direction_control <= $urandom;
      pullup_request         <= $urandom;
      bus(1'b1, OFF_PIN_EN, e, 32'h0);
      repeat (2) @(posedge clk);
      chk("analog enables", e, analog_pin_enables);
      chk("digital off", e, pin_digital_off);
      chk("input dir", port_direction_control | e, pin_input_dir);
      chk("pull-high", pullup_request & ~e, pin_pullup_on);
    end
    $display("test pin selection done");

    bus(1'b1, OFF_CTRL1, 8'hD0, 32'h0);
    chk("ref select", 32'h1, reference_source_sel);
    chk("ref pin shared off", 32'h1, vref_pin_shared_off);
    chk("bandgap route", 32'h1, bandgap_route);
    chk("bandgap enable", 32'h1, bandgap_enable);
    bus(1'b0, OFF_CTRL1, 8'h00, 32'h000000D0);
    bus(1'b1, OFF_CTRL1, 8'h00, 32'h0);
    chk("ref select low", 32'h0, reference_source_sel);
    chk("bandgap off", 32'h0, bandgap_enable);
    $display("test reference done");

    for (int dv = 0; dv < 7; dv++) begin
      ch = $urandom;
      d  = $urandom;
      al = dv[0];
      en = (dv < 4);
      conv_result_data <= d;
      per = 1 << dv;
      bus(1'b1, OFF_CTRL1, {5'h00, 3'(dv)}, 32'h0);
      bus(1'b1, OFF_EVENT, {6'h00, en, 1'b1}, 32'h0);
      bus(1'b1, OFF_CTRL0, {3'b000, al, 1'b0, ch}, 32'h0);
      chk("power on", 32'h1, conv_power_on);
      chk("channel", ch, conv_channel);
      repeat (SETTLE_CYC) @(posedge clk);
      bus(1'b1, OFF_CTRL0, {3'b100, al, 1'b0, ch}, 32'h0);
      @(posedge clk);
      chk("converter reset", 32'h1, conv_reset);
      bus(1'b0, OFF_CTRL0, 8'h00, {24'h0, 3'b110, al, 1'b0, ch});
      step_clr <= 1'b1;
      @(posedge clk);
      step_clr <= 1'b0;
      bus(1'b1, OFF_CTRL0, {3'b000, al, 1'b0, ch}, 32'h0);
      repeat ((16 << dv) + 4) @(posedge clk);
      chk("step count", 32'd16, step_cnt);
      chk("step spacing", 32'd0, gap_err);
      chk("irq", en, conv_irq);
      bus(1'b0, OFF_CTRL0, 8'h00, {24'h0, 3'b000, al, 1'b0, ch});
      bus(1'b0, OFF_RESULT, 8'h00, al ? {20'h0, d} : {16'h0, d, 4'h0});
      bus(1'b0, OFF_EVENT, 8'h00, {29'h0, dv == 6, en, 1'b1});
      bus(1'b1, OFF_EVENT, 8'h03, 32'h0);
      chk("irq cleared", 32'h0, conv_irq);
    end
    $display("test conversions done");

    bus(1'b1, OFF_CTRL1, 8'h07, 32'h0);
    bus(1'b1, OFF_CTRL0, 8'h80, 32'h0);
    step_clr <= 1'b1;
    @(posedge clk);
    step_clr <= 1'b0;
    bus(1'b1, OFF_CTRL0, 8'h00, 32'h0);
    repeat (300) @(posedge clk);
    chk("steps on undefined code", 32'd0, step_cnt);
    bus(1'b0, OFF_CTRL0, 8'h00, 32'h00000040);
    // Raising start on the stalled run must abort it, and a fresh trigger must then complete.
    per = 1;
    bus(1'b1, OFF_CTRL0, 8'h80, 32'h0);
    bus(1'b1, OFF_CTRL1, 8'h00, 32'h0);
    step_clr <= 1'b1;
    @(posedge clk);
    step_clr <= 1'b0;
    bus(1'b1, OFF_CTRL0, 8'h00, 32'h0);
    repeat (24) @(posedge clk);
    chk("steps after restart", 32'd16, step_cnt);
    chk("spacing after restart", 32'd0, gap_err);
    $display("test undefined divider done");
    repeat (2) @(posedge clk);
    finish_test();
  end
endmodule // adc_conversion_control_tb

//--- hw/adc_conversion_control.sv
/*
  Conversion control for a 12-bit successive approximation converter:
  start and reset sequencing, busy flag, completion event, conversion
  clock, power, reference and analog pin selection, register bus slave.
  Assumes the analog core and port logic run on clk and that the result
  word is stable when the last conversion step has been issued.
*/
// Implementation choices: the placing of the registers and the Avalon-MM register port.
// Function
// [R01] A conversion starts once software writes the start bit high and then low again.
// [R02] While the start bit is high the converter is held in reset and the busy flag reads one.
// [R03] The busy flag clears to zero on its own when a conversion ends.
// [R04] Completion sets the request flag, and the interrupt line rises only when enabled.
// [R05] The conversion clock is the system clock divided by 1 to 64 for codes 0 to 6.
// [R06] Software should keep the conversion clock period between 0.5 us and 10 us.
// [R07] The converter is powered only while the power-down bit is zero.
// [R08] Software waits a settling delay after power-up before starting a conversion.
// [R09] The reference select bit takes the reference from the pin and frees that pin of other uses.
// [R10] Each analog enable bit turns its pin into a converter input and drops its digital uses.
// [R11] A pull-high on a pin is disconnected while that pin is an analog input.
// [R12] An analog enable overrides the port direction setting of its pin.
// [R13] A conversion lasts sixteen conversion clock periods from trigger to busy clear.
// [R14] The result is left aligned when the format bit is zero, else right aligned, spare bits zero.
// [R15] The undefined divider code gives no conversion clock edges.
`timescale 1ns/1ps
module adc_conversion_control
  import adc_ctrl_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [3:0]        avs_byteenable,
  input  wire logic [31:0]       avs_writedata,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  input  wire logic [RES_W-1:0]  conv_result_data,
  output logic                   conv_reset,
  output logic                   conv_step,
  output logic                   conv_power_on,
  output logic [2:0]             conv_channel,
  output logic                   bandgap_route,
  output logic                   bandgap_enable,
  output logic                   reference_source_sel,
  output logic                   vref_pin_shared_off,
  input  wire logic [PINS-1:0]   port_direction_control,
  input  wire logic [PINS-1:0]   pullup_request,
  output logic [PINS-1:0]        analog_pin_enables,
  output logic [PINS-1:0]        pin_digital_off,
  output logic [PINS-1:0]        pin_input_dir,
  output logic [PINS-1:0]        pin_pullup_on,
  output logic                   conv_irq
);

  // ----------------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------------
  logic             start_r;
  logic             busy_r;
  logic             busy_nxt;
  logic             pdown_r;
  logic             align_r;
  logic [2:0]       chan_r;
  logic             bgsel_r;
  logic             bgen_r;
  logic             reference_source_sel_r;
  logic [2:0]       div_r;
  logic [PINS-1:0]  pin_en_r;
  logic             flag_r;
  logic             flag_nxt;
  logic             irq_en_r;
  logic [RES_W-1:0] result_r;
  logic             ack_r;
  logic [31:0]      rdata_r;
  logic [31:0]      rdata_nxt;
  logic [3:0]       tick_cnt_r;
  logic [3:0]       tick_cnt_nxt;
  conv_state_t      state_r;
  conv_state_t      state_nxt;

  conv_clk_if clk_link ();

  conv_clock_divider #(
    .DIV_W (6)
  ) u_div (
    .clk   (clk),
    .reset (reset),
    .link  (clk_link)
  );

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  // One wait cycle per access keeps read data registered and timing simple.
  wire        req       = avs_read || avs_write;
  wire        wr_fire   = avs_write && ack_r;
  wire        wr_lane0  = wr_fire && avs_byteenable[0];
  wire        wr_ctrl0  = wr_lane0 && (avs_address == OFF_CTRL0);
  wire        wr_ctrl1  = wr_lane0 && (avs_address == OFF_CTRL1);
  wire        wr_pin_en = wr_lane0 && (avs_address == OFF_PIN_EN);
  wire        wr_event  = wr_lane0 && (avs_address == OFF_EVENT);
  wire [7:0]  wd        = avs_writedata[7:0];

  assign avs_waitrequest = req && !ack_r;
  assign avs_readdata    = rdata_r;

  // ----------------------------------------------------------------------
  // Result formatting and status
  // ----------------------------------------------------------------------
  function automatic logic [15:0] fmt_result(input logic right, input logic [RES_W-1:0] d);
    fmt_result = right ? {ALIGN_PAD, d} : {d, ALIGN_PAD};
  endfunction

  function automatic logic [7:0] period_cycles(input logic [2:0] s);
    period_cycles = 8'(1 << s);
  endfunction

  wire [15:0] result_word = fmt_result(align_r, result_r); // [R14]
  // Advisory only: the hardware does not refuse a setting outside the range.
  wire        range_ok    = (div_r != DIV_UNDEFINED)
                         && (int'(period_cycles(div_r)) >= ADCK_MIN_CYC)
                         && (int'(period_cycles(div_r)) <= ADCK_MAX_CYC); // [R06]

  wire [7:0] ctrl0_rd = {start_r, busy_r, pdown_r, align_r, 1'b0, chan_r};
  wire [7:0] ctrl1_rd = {bgsel_r, bgen_r, 1'b0, reference_source_sel_r, 1'b0, div_r};
  wire [7:0] event_rd = {5'h00, range_ok, irq_en_r, flag_r};

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    case (avs_address)
      OFF_CTRL0:  rdata_nxt = {24'h00_0000, ctrl0_rd};
      OFF_CTRL1:  rdata_nxt = {24'h00_0000, ctrl1_rd};
      OFF_PIN_EN: rdata_nxt = {24'h00_0000, pin_en_r};
      OFF_RESULT: rdata_nxt = {16'h0000, result_word};
      OFF_EVENT:  rdata_nxt = {24'h00_0000, event_rd};
      default:    rdata_nxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ack_r   <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      ack_r   <= req && !ack_r;
      rdata_r <= (avs_read && !ack_r) ? rdata_nxt : rdata_r;
    end
  end

  // ----------------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      start_r  <= 1'b0;
      pdown_r  <= PDOWN_RST;
      align_r  <= 1'b0;
      chan_r   <= CHAN_RST;
    end else if (wr_ctrl0) begin
      start_r  <= wd[C0_START];
      pdown_r  <= wd[C0_PDOWN];
      align_r  <= wd[C0_ALIGN];
      chan_r   <= wd[C0_CHAN_LO +: 3];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      bgsel_r  <= 1'b0;
      bgen_r   <= 1'b0;
      reference_source_sel_r  <= 1'b0;
      div_r    <= DIV_RST;
    end else if (wr_ctrl1) begin
      bgsel_r  <= wd[C1_BGSEL];
      bgen_r   <= wd[C1_BGEN];
      reference_source_sel_r  <= wd[C1_REFERENCE_SOURCE_SEL];
      div_r    <= wd[C1_DIV_LO +: 3];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) pin_en_r <= PIN_EN_RST;
    else if (wr_pin_en) pin_en_r <= wd;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) irq_en_r <= 1'b0;
    else if (wr_event) irq_en_r <= wd[EV_ENABLE];
  end

  // ----------------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------------
  wire last_tick = (tick_cnt_r == 4'(CONV_TICKS - 1));
  wire step      = (state_r == ST_CONV) && clk_link.tick && conv_power_on;
  // A start raised on the last step aborts the run, so it must not count as a completion.
  wire done      = step && last_tick && !start_r;

  always_comb begin
    state_nxt    = state_r;
    tick_cnt_nxt = tick_cnt_r;
    case (state_r)
      ST_IDLE: begin
        if (start_r) state_nxt = ST_HOLD;
      end
      ST_HOLD: begin
        tick_cnt_nxt = 4'h0;
        if (!start_r) state_nxt = ST_CONV; // [R01]
      end
      ST_CONV: begin
        if (start_r) begin
          state_nxt = ST_HOLD;
        end else if (step) begin
          tick_cnt_nxt = tick_cnt_r + 4'h1;
          if (last_tick) state_nxt = ST_IDLE; // [R13]
        end
      end
      default: begin
        state_nxt    = ST_IDLE;
        tick_cnt_nxt = 4'h0;
      end
    endcase
  end

  // A raised start bit always wins, so busy reads one even as a run ends.
  assign busy_nxt = (state_nxt != ST_IDLE) ? 1'b1 : (done ? 1'b0 : busy_r); // [R02] [R03]

  // The event flag is write-one-to-clear; a completion in the same cycle wins.
  assign flag_nxt = done || (flag_r && !(wr_event && wd[EV_FLAG])); // [R04]

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_r    <= ST_IDLE;
      tick_cnt_r <= 4'h0;
      busy_r     <= BUSY_RST;
      flag_r     <= 1'b0;
      result_r   <= '0;
    end else begin
      state_r    <= state_nxt;
      tick_cnt_r <= tick_cnt_nxt;
      busy_r     <= busy_nxt;
      flag_r     <= flag_nxt;
      result_r   <= done ? conv_result_data : result_r;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs to core and pins
  // ----------------------------------------------------------------------
  assign clk_link.sel   = div_r; // [R05]
  assign clk_link.clear = (state_r != ST_CONV);

  assign conv_reset           = (state_r == ST_HOLD); // [R02]
  assign conv_step            = step;
  assign conv_power_on        = !pdown_r; // [R07]
  assign conv_channel         = chan_r;
  assign bandgap_route        = bgsel_r;
  assign bandgap_enable       = bgen_r;
  assign reference_source_sel = reference_source_sel_r; // [R09]
  assign vref_pin_shared_off  = reference_source_sel_r; // [R09]
  assign analog_pin_enables   = pin_en_r; // [R10]
  assign pin_digital_off      = pin_en_r; // [R10]
  assign pin_input_dir        = port_direction_control | pin_en_r; // [R12]
  assign pin_pullup_on        = pullup_request & ~pin_en_r; // [R11]
  assign conv_irq             = flag_r && irq_en_r; // [R04]

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  property p_hold_busy;
    @(posedge clk) disable iff (reset) (state_r == ST_HOLD) |-> (busy_r && conv_reset && !conv_step);
  endproperty
  a_hold_busy: assert property (p_hold_busy) else $error("held reset without busy"); // [R02]

  property p_trigger;
    @(posedge clk) disable iff (reset) (state_r == ST_HOLD && !start_r) |=> (state_r == ST_CONV && busy_r);
  endproperty
  a_trigger: assert property (p_trigger) else $error("start fall did not begin conversion"); // [R01]

  property p_done_clears;
    @(posedge clk) disable iff (reset) (done && !start_r) |=> (!busy_r && state_r == ST_IDLE);
  endproperty
  a_done_clears: assert property (p_done_clears) else $error("busy not cleared at end"); // [R03]

  property p_flag_set;
    @(posedge clk) disable iff (reset) done |=> flag_r;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("completion flag missing"); // [R04]

  property p_irq_gate;
    @(posedge clk) disable iff (reset) (flag_r && !irq_en_r) |-> !conv_irq;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("interrupt raised while disabled"); // [R04]

  property p_flag_clear;
    @(posedge clk) disable iff (reset) (wr_event && wd[EV_FLAG] && !done) |=> !flag_r;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("completion flag not cleared"); // [R04]

  // Steps are counted apart from the sequencer so that a slip in its counter cannot hide.
  logic [4:0] steps_seen_r;
  always_ff @(posedge clk or posedge reset) begin
    if (reset)                   steps_seen_r <= 5'h00;
    else if (state_r != ST_CONV) steps_seen_r <= 5'h00;
    else if (conv_step)          steps_seen_r <= steps_seen_r + 5'h01;
  end

  property p_sixteen;
    @(posedge clk) disable iff (reset) done |-> (steps_seen_r == 5'(CONV_TICKS - 1));
  endproperty
  a_sixteen: assert property (p_sixteen) else $error("conversion length not sixteen"); // [R13]

  property p_div1_len;
    @(posedge clk) disable iff (reset)
      (state_r == ST_HOLD && !start_r && div_r == 3'h0 && !pdown_r && !wr_ctrl0 && !wr_ctrl1)
      ##1 (!start_r && !pdown_r && div_r == 3'h0) [*8] |=> (tick_cnt_r == 4'h8);
  endproperty
  a_div1_len: assert property (p_div1_len) else $error("divide by one step rate wrong"); // [R05]

  property p_pdown_idle;
    @(posedge clk) disable iff (reset) pdown_r |-> !conv_step;
  endproperty
  a_pdown_idle: assert property (p_pdown_idle) else $error("step while powered down"); // [R07]

  property p_pin_override;
    @(posedge clk) disable iff (reset) ((pin_pullup_on & pin_en_r) == 8'h00) && ((pin_input_dir & pin_en_r) == pin_en_r);
  endproperty
  a_pin_override: assert property (p_pin_override) else $error("analog pin keeps pull-up or output"); // [R11] [R12]

  property p_left_align;
    @(posedge clk) disable iff (reset) !align_r |-> (result_word[3:0] == 4'h0 && result_word[15:4] == result_r);
  endproperty
  a_left_align: assert property (p_left_align) else $error("left aligned result wrong"); // [R14]

  property p_ref_pin;
    @(posedge clk) disable iff (reset) $rose(reference_source_sel_r) |-> (vref_pin_shared_off && reference_source_sel);
  endproperty
  a_ref_pin: assert property (p_ref_pin) else $error("reference pin not taken over"); // [R09]

  c_conv_done:  cover property (@(posedge clk) disable iff (reset) done);
  c_restart:    cover property (@(posedge clk) disable iff (reset) state_r == ST_CONV && start_r);
  c_irq:        cover property (@(posedge clk) disable iff (reset) $rose(conv_irq));
  c_flag_race:  cover property (@(posedge clk) disable iff (reset) done && wr_event && wd[EV_FLAG]);
  c_undef_stall: cover property (@(posedge clk) disable iff (reset) state_r == ST_CONV && div_r == DIV_UNDEFINED);

endmodule // adc_conversion_control

//--- hw/conv_clock_divider.sv
/*
  Conversion clock divider: one tick per conversion clock period.
  Assumes select and clear come from logic on the same clock.
*/
`timescale 1ns/1ps
module conv_clock_divider
  import adc_ctrl_pkg::*;
#(
  parameter int DIV_W = 6
) (
  input  wire logic clk,
  input  wire logic reset,
  conv_clk_if.div   link
);

  logic [DIV_W-1:0] cnt_r;
  logic [DIV_W-1:0] cnt_nxt;
  logic [DIV_W-1:0] term;
  wire              valid_sel = (link.sel != DIV_UNDEFINED);

  function automatic logic [DIV_W-1:0] div_mask(input logic [2:0] s);
    div_mask = DIV_W'((1 << s) - 1);
  endfunction

  assign term      = div_mask(link.sel);
  // An undefined code stops the ticks so nothing advances on a bad setting.
  assign link.tick = valid_sel && !link.clear && (cnt_r == term); // [R05] [R15]
  assign cnt_nxt   = (link.clear || !valid_sel || link.tick) ? '0 : cnt_r + 1'b1;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) cnt_r <= '0;
    else       cnt_r <= cnt_nxt;
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  property p_no_tick_undef;
    @(posedge clk) disable iff (reset) (link.sel == DIV_UNDEFINED) |-> !link.tick;
  endproperty
  a_no_tick_undef: assert property (p_no_tick_undef) else $error("tick on undefined divider code"); // [R15]

  property p_div8_spacing;
    @(posedge clk) disable iff (reset)
      (link.tick && link.sel == 3'h3) ##1 (link.sel == 3'h3 && !link.clear) [*8] |-> link.tick;
  endproperty
  a_div8_spacing: assert property (p_div8_spacing) else $error("divide by 8 spacing wrong"); // [R05]

endmodule // conv_clock_divider

//--- inc/adc_ctrl_pkg.sv
/*
  Shared constants for the converter control block: register map, field
  positions, reset values, state codes and timing figures.
  Assumes a 125 MHz system clock and a 32-bit Avalon-MM register bus.
*/
package adc_ctrl_pkg;

  // ----------------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam int          ADDR_W              = 5;
  localparam logic [4:0]  OFF_CTRL0           = 5'h00;
  localparam logic [4:0]  OFF_CTRL1           = 5'h04;
  localparam logic [4:0]  OFF_PIN_EN          = 5'h08;
  localparam logic [4:0]  OFF_RESULT          = 5'h0C;
  localparam logic [4:0]  OFF_EVENT           = 5'h10;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int          C0_START            = 7;
  localparam int          C0_BUSY             = 6;
  localparam int          C0_PDOWN            = 5;
  localparam int          C0_ALIGN            = 4;
  localparam int          C0_CHAN_LO          = 0;
  localparam int          C1_BGSEL            = 7;
  localparam int          C1_BGEN             = 6;
  localparam int          C1_REFERENCE_SOURCE_SEL            = 4;
  localparam int          C1_DIV_LO           = 0;
  localparam int          EV_FLAG             = 0;
  localparam int          EV_ENABLE           = 1;
  localparam int          EV_RANGE_OK         = 2;

  // ----------------------------------------------------------------------
  // Widths, reset values and codes
  // ----------------------------------------------------------------------
  localparam int          RES_W               = 12;
  localparam int          PINS                = 8;
  localparam logic [2:0]  DIV_UNDEFINED       = 3'h7;
  localparam logic [2:0]  CHAN_RST            = 3'h0;
  localparam logic [2:0]  DIV_RST             = 3'h0;
  localparam logic [7:0]  PIN_EN_RST          = 8'hFF;
  localparam logic        BUSY_RST            = 1'b1;
  localparam logic        PDOWN_RST           = 1'b1;
  localparam logic [3:0]  ALIGN_PAD           = 4'h0;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int          CONV_TICKS          = 16;
  localparam int          CLK_PERIOD_NS       = 8;
  localparam int          ADCK_MIN_NS         = 500;
  localparam int          ADCK_MAX_NS         = 10000;
  localparam int          ADCK_MIN_CYC        = (ADCK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          ADCK_MAX_CYC        = ADCK_MAX_NS / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_HOLD = 3'b010,
    ST_CONV = 3'b100
  } conv_state_t;

endpackage

//--- inc/conv_clk_if.sv
/*
  Link between the conversion controller and its clock divider.
  Assumes both ends run on the same system clock.
*/
`timescale 1ns/1ps
interface conv_clk_if;
  logic [2:0] sel;
  logic       clear;
  logic       tick;
  modport ctrl (output sel, output clear, input tick);
  modport div  (input sel, input clear, output tick);
endinterface
